/* shared/meas_pkg.sv */
// constants and types shared by the measurement handshake block
package meas_pkg;
  // ******************************************
  // register map (apb byte addresses)
  // ******************************************
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] PWIDTH_ADDR = 12'h004;
  localparam logic [11:0] RESULT_ADDR = 12'h008;
  localparam logic [11:0] STATUS_ADDR = 12'h00c;
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h010;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h014;
  localparam logic [11:0] GAP_ADDR = 12'h018;
  // ctrl fields
  localparam int CTRL_INT_MEASURE_START_IN = 0;
  localparam int CTRL_PULSE = 1;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_READY = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // result fields
  localparam int RES_ABOVE = 0;
  localparam int RES_WITHIN = 1;
  localparam int RES_UNDER = 2;
  localparam int RES_FAULT = 3;
  localparam int RES_OUTSIDE = 4;
  localparam int RES_CLASS = 5;
  localparam int RES_W = 15;
  // irq status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_IGNORED = 1;
  localparam int IRQ_RECALL = 2;
  localparam int IRQ_W = 3;
  // ******************************************
  // timing
  // ******************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int PW_MIN_MS = 1;
  localparam int PW_MAX_MS = 100;
  localparam int PW_RESET_MS = 10;
  localparam int INT_PULSE_MS = 5;
  localparam int RECALL_MS = 10;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int RECALL_CYC = RECALL_MS * CYC_PER_MS;
  localparam int INT_PULSE_CYC = INT_PULSE_MS * CYC_PER_MS;
  localparam logic [6:0] PW_RESET = 7'(PW_RESET_MS);
  typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_GAP} meas_state_t;
endpackage : meas_pkg

/* hdl/meas_handshake.sv */
// apb-controlled measurement start/done handshake with judgment outputs
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
module meas_handshake #(
  parameter int CYC_PER_MS_P = meas_pkg::CYC_PER_MS,
  parameter int RECALL_CYC_P = meas_pkg::RECALL_CYC,
  parameter int INT_PULSE_CYC_P = meas_pkg::INT_PULSE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic measure_start_in,
  input wire logic recall_in,
  output logic measure_done_out,
  output logic above_limit_out,
  output logic within_limit_out,
  output logic under_limit_out,
  output logic fault_out,
  output logic outside_classes_out,
  output logic [9:0] class_match_out,
  output logic meas_busy_out,
  output logic irq_out
);
  import meas_pkg::*;

  // ******************************************
  // state
  // ******************************************
  typedef struct packed {
    logic [2:0] start_sync;
    logic [2:0] recall_sync;
    logic [3:0] ctrl;
    logic [6:0] pwidth;
    logic [15:0] gap_ms;
    logic [RES_W-1:0] staged;
    logic [RES_W-1:0] result;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    meas_state_t st;
    logic done;
    logic ready_seen;
    logic [31:0] cnt;
    logic [31:0] dcnt;
    logic [23:0] rcnt;
    logic recalling;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic start_edge;
  logic recall_lvl;
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  logic launch;
  logic finish;
  logic [IRQ_W-1:0] ev;
  logic [6:0] pw_clip;

  always_comb begin
    s_next = s_reg;
    ev = '0;
    launch = 1'b0;
    finish = 1'b0;
    // three-flop synchronisers; only stage 1 and 2 feed logic
    s_next.start_sync = {s_reg.start_sync[1:0], measure_start_in};
    s_next.recall_sync = {s_reg.recall_sync[1:0], recall_in};
    start_edge = s_reg.start_sync[1] & ~s_reg.start_sync[2];
    recall_lvl = s_reg.recall_sync[1];

    // ******************************************
    // apb slave, one wait state
    // ******************************************
    acc = psel & penable & ~s_reg.ready;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    mapped = (paddr[11:5] == 7'h00) && (paddr[4:2] != 3'h7)
      && (paddr[1:0] == 2'h0);
    s_next.ready = acc;
    s_next.err = acc & ~mapped;
    if (rd) begin
      unique case (paddr)
        CTRL_ADDR: s_next.rdata = {28'h0, s_reg.ctrl};
        PWIDTH_ADDR: s_next.rdata = {25'h0, s_reg.pwidth};
        RESULT_ADDR: s_next.rdata = {17'h0, s_reg.result};
        STATUS_ADDR: s_next.rdata = {28'h0, s_reg.recalling,
          s_reg.st != ST_IDLE, s_reg.done, s_reg.ready_seen};
        IRQ_STAT_ADDR: s_next.rdata = {29'h0, s_reg.irq_stat};
        IRQ_MASK_ADDR: s_next.rdata = {29'h0, s_reg.irq_mask};
        GAP_ADDR: s_next.rdata = {16'h0, s_reg.gap_ms};
        default: s_next.rdata = 32'h0;
      endcase
    end else begin
      s_next.rdata = 32'h0;
    end
    // out-of-range width clipped into 1..100 ms
    pw_clip = pwdata[6:0];
    // compare the full word so large values clip instead of wrapping
    if (pwdata < 32'(PW_MIN_MS)) begin
      pw_clip = 7'(PW_MIN_MS);
    end else if (pwdata > 32'(PW_MAX_MS)) begin
      pw_clip = 7'(PW_MAX_MS);
    end
    if (wr && mapped) begin
      case (paddr)
        CTRL_ADDR: s_next.ctrl = pwdata[3:0];
        PWIDTH_ADDR: s_next.pwidth = pw_clip;
        IRQ_MASK_ADDR: s_next.irq_mask = pwdata[IRQ_W-1:0];
        GAP_ADDR: s_next.gap_ms = pwdata[15:0];
        RESULT_ADDR: s_next.staged = pwdata[RES_W-1:0];
        default: ;
      endcase
    end

    // ******************************************
    // settings recall
    // ******************************************
    if (recall_lvl && !s_reg.recalling) begin
      s_next.rcnt = s_reg.rcnt + 24'h1;
      if (s_reg.rcnt == 24'(RECALL_CYC_P - 1)) begin
        s_next.recalling = 1'b1;
      end
    end else if (!recall_lvl) begin
      s_next.rcnt = 24'h0;
      if (s_reg.recalling) begin
        s_next.recalling = 1'b0;
        ev[IRQ_RECALL] = 1'b1;
      end
    end

    // ******************************************
    // power-up: done follows mode once measurement state is reached
    // ******************************************
    if (s_reg.ctrl[CTRL_READY] && !s_reg.ready_seen) begin
      s_next.ready_seen = 1'b1;
      s_next.done = ~s_reg.ctrl[CTRL_PULSE];
    end

    // done pulse timer; width in ms from pwidth register in pulse mode, INT_PULSE_CYC_P cycles in internal-start mode
    if (s_reg.done && s_reg.dcnt != 32'h0) begin
      s_next.dcnt = s_reg.dcnt - 32'h1;
      if (s_reg.dcnt == 32'h1) begin
        s_next.done = 1'b0;
      end
    end

    // ******************************************
    // measurement sequencer
    // ******************************************
    case (s_reg.st)
      ST_IDLE: begin
        if (s_reg.ctrl[CTRL_INT_MEASURE_START_IN]) begin
          launch = s_reg.ctrl[CTRL_RUN] & s_reg.ready_seen
            & ~s_reg.recalling;
        end else if (start_edge) begin
          // hold mode: start only honoured while done is high
          if (s_reg.recalling || !s_reg.ready_seen) begin
            ev[IRQ_IGNORED] = 1'b1;
          end else if (!s_reg.ctrl[CTRL_PULSE] && !s_reg.done) begin
            ev[IRQ_IGNORED] = 1'b1;
          end else begin
            launch = 1'b1;
          end
        end
      end
      ST_MEAS: begin
        if (start_edge) begin
          ev[IRQ_IGNORED] = 1'b1;
        end
        // measurement time is external; software writes the result
        if (wr && paddr == RESULT_ADDR) begin
          finish = 1'b1;
        end
      end
      ST_GAP: begin
        if (s_reg.cnt == 32'h0) begin
          s_next.st = ST_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt - 32'h1;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase

    if (launch) begin
      s_next.st = ST_MEAS;
      // internal relaunch leaves the running done pulse to its timer
      if (!s_reg.ctrl[CTRL_INT_MEASURE_START_IN]) begin
        s_next.done = 1'b0;
        s_next.dcnt = 32'h0;
      end
      // judgments keep their value until the next completion
    end
    if (finish) begin
      s_next.result = pwdata[RES_W-1:0];
      s_next.done = 1'b1;
      ev[IRQ_DONE] = 1'b1;
      if (s_reg.ctrl[CTRL_INT_MEASURE_START_IN]) begin
        s_next.dcnt = 32'(INT_PULSE_CYC_P);
        // zero gap skips straight back to idle, no dead time
        if (s_reg.gap_ms == 16'h0) begin
          s_next.st = ST_IDLE;
        end else begin
          s_next.st = ST_GAP;
          s_next.cnt = 32'(s_reg.gap_ms) * 32'(CYC_PER_MS_P) - 32'h1;
        end
      end else begin
        s_next.st = ST_IDLE;
        s_next.dcnt = s_reg.ctrl[CTRL_PULSE]
          ? 32'(s_reg.pwidth) * 32'(CYC_PER_MS_P) : 32'h0;
      end
    end

    // ******************************************
    // interrupts: set wins over read-clear
    // ******************************************
    if (rd && paddr == IRQ_STAT_ADDR) begin
      s_next.irq_stat = ev;
    end else begin
      s_next.irq_stat = s_reg.irq_stat | ev;
    end
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.pwidth <= PW_RESET;
      s_reg.st <= ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.err;
  assign measure_done_out = s_reg.done;
  assign above_limit_out = s_reg.result[RES_ABOVE];
  assign within_limit_out = s_reg.result[RES_WITHIN];
  assign under_limit_out = s_reg.result[RES_UNDER];
  assign fault_out = s_reg.result[RES_FAULT];
  assign outside_classes_out = s_reg.result[RES_OUTSIDE];
  assign class_match_out = s_reg.result[RES_CLASS +: 10];
  assign meas_busy_out = s_reg.st == ST_MEAS;
  assign irq_out = s_reg.irq;
endmodule : meas_handshake

/* sim/meas_handshake_sva.sv */
// port assertions for the measurement handshake block
`timescale 1ns/10ps
module meas_handshake_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic measure_done_out,
  input wire logic above_limit_out,
  input wire logic within_limit_out,
  input wire logic under_limit_out,
  input wire logic fault_out,
  input wire logic outside_classes_out,
  input wire logic [9:0] class_match_out,
  input wire logic meas_busy_out
);
  logic [14:0] judg;
  assign judg = {class_match_out, outside_classes_out, fault_out,
                 under_limit_out, within_limit_out, above_limit_out};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not idle");
  AST_SLVERR_MAP: assert property (pready |->
    pslverr == (paddr >= 12'h01c || paddr[1:0] != 2'h0))
    else $error("pslverr decode");
  AST_SLVERR_QUAL: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  AST_DONE_AT_END: assert property (
    $fell(meas_busy_out) |-> measure_done_out) else $error("end no done");
  AST_BUSY_ENDS: assert property (
    $rose(measure_done_out) |-> !meas_busy_out)
    else $error("busy stuck");
  AST_RESULT_DONE: assert property (
    $changed(judg) |-> $rose(measure_done_out)) else $error("result moved");
endmodule : meas_handshake_sva
bind meas_handshake meas_handshake_sva meas_handshake_sva_i (.pclk,
  .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .measure_done_out, .above_limit_out, .within_limit_out,
  .under_limit_out, .fault_out, .outside_classes_out, .class_match_out,
  .meas_busy_out);

/* sim/ctrl_model.sv */
// external controller driving start and recall pins
`timescale 1ns/10ps
module ctrl_model #(
  parameter int MS = 10
) (
  input wire logic pclk,
  output logic measure_start_in,
  output logic recall_in
);
  initial begin
    measure_start_in = 1'b0;
    recall_in = 1'b0;
  end
  task automatic start_pulse();
    repeat (MS) @(posedge pclk);
    measure_start_in <= 1'b1;
    repeat (MS) @(posedge pclk);
    measure_start_in <= 1'b0;
  endtask : start_pulse
  task automatic recall(input int n);
    @(posedge pclk);
    recall_in <= 1'b1;
    repeat (n) @(posedge pclk);
    recall_in <= 1'b0;
  endtask : recall
  task automatic settle();
    repeat (100 * MS) @(posedge pclk);
  endtask : settle
endmodule : ctrl_model

/* sim/tb_meas_handshake.sv */
// self-checking bench for the measurement handshake block
`timescale 1ns/10ps
module tb_meas_handshake;
  import meas_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, st, rc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic done, ab, wi, un, ft, ob, busy, irq, er;
  logic [9:0] cls;
  int bad_count = 0;
  int n_checks = 0;
  meas_handshake #(.CYC_PER_MS_P(10), .RECALL_CYC_P(20),
    .INT_PULSE_CYC_P(5)) meas_handshake_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .measure_start_in(st), .recall_in(rc), .measure_done_out(done),
    .above_limit_out(ab), .within_limit_out(wi), .under_limit_out(un),
    .fault_out(ft), .outside_classes_out(ob), .class_match_out(cls),
    .meas_busy_out(busy), .irq_out(irq));
  ctrl_model #(.MS(10)) ctrl_model_i (.pclk, .measure_start_in(st),
    .recall_in(rc));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rst();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : rst
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    rst();
    chk(done, 1'b0);
    apb(0, PWIDTH_ADDR, 0);
    chk(rd, 32'(PW_RESET_MS));
    apb(0, 12'h01c, 0);
    chk(er, 1'b1);
    apb(1, CTRL_ADDR, 32'h8);
    chk(done, 1'b1);
    ctrl_model_i.settle();
    apb(1, IRQ_MASK_ADDR, 32'h2);
    ctrl_model_i.start_pulse();
    chk({done, busy}, 2'b01);
    chk(irq, 1'b0);
    ctrl_model_i.start_pulse();
    chk(irq, 1'b1);
    apb(0, IRQ_STAT_ADDR, 0);
    chk(rd[IRQ_IGNORED], 1'b1);
    apb(1, RESULT_ADDR, 32'h23);
    chk({done, ab, cls, busy}, {2'b11, 10'h001, 1'b0});
    repeat (30) @(posedge pclk);
    chk({done, irq}, 2'b10);
    rst();
    apb(1, CTRL_ADDR, 32'ha);
    chk(done, 1'b0);
    apb(1, PWIDTH_ADDR, 32'hc8);
    apb(0, PWIDTH_ADDR, 0);
    chk(rd, 32'h64);
    apb(1, PWIDTH_ADDR, 32'h0);
    apb(0, PWIDTH_ADDR, 0);
    chk(rd, 32'h1);
    apb(1, PWIDTH_ADDR, 32'h2);
    ctrl_model_i.start_pulse();
    apb(1, RESULT_ADDR, 32'h4);
    repeat (15) @(posedge pclk);
    chk({done, un}, 2'b11);
    repeat (10) @(posedge pclk);
    chk(done, 1'b0);
    apb(1, PWIDTH_ADDR, 32'h64);
    ctrl_model_i.start_pulse();
    apb(1, RESULT_ADDR, 32'h1);
    ctrl_model_i.start_pulse();
    chk({done, busy, ab}, 3'b011);
    apb(1, RESULT_ADDR, 32'h2);
    fork
      ctrl_model_i.recall(60);
    join_none
    repeat (40) @(posedge pclk);
    ctrl_model_i.start_pulse();
    chk(busy, 1'b0);
    repeat (1000) @(posedge pclk);
    chk(done, 1'b0);
    apb(1, GAP_ADDR, 32'h0);
    apb(1, CTRL_ADDR, 32'hd);
    repeat (4) @(posedge pclk);
    chk(busy, 1'b1);
    apb(1, RESULT_ADDR, 32'h1);
    chk(done, 1'b1);
    repeat (3) @(posedge pclk);
    chk({busy, ab}, 2'b11);
    repeat (3) @(posedge pclk);
    chk(done, 1'b0);
    apb(1, CTRL_ADDR, 32'h0);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end
endmodule : tb_meas_handshake
